// ==== bench/tb.sv ====
/*
 Self-checking bench for uoinh_core: registers, IN NAK flow, host view.
 Assumes the peer model and the bound checker.
*/
`timescale 1ns/1ps
module tb;
    import uoinh_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    uoinh_bus_t bus = '0;
    logic host = 1'b0;
    logic [NCHAN-1:0] flags = '0;
    logic [1:0] spd = 2'h0;
    logic conn = 1'b0;
    logic [31:0] rx = 32'h0000_0000;
    uoinh_tok_t tok;
    uoinh_reply_t rep;
    uoinh_reply_t r;
    logic [31:0] rdata;
    logic [31:0] d;
    logic virq;
    logic cirq;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    uoinh_core i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
        .i_host_mode(host), .i_chan_flags(flags), .i_speed(spd), .i_conn_det(conn),
        .i_en_chng(1'b0), .i_ovc_chng(1'b0), .i_tok(tok), .o_reply(rep),
        .i_rx_word(rx), .o_vreg_irq(virq), .o_core_irq(cirq));
    uoinh_peer i_peer (.i_ref_clk(i_ref_clk), .i_reply(rep), .o_tok(tok));
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        @(posedge i_ref_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge i_ref_clk);
        bus <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
        @(posedge i_ref_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge i_ref_clk);
        bus <= '0;
        #1;
        v = rdata;
    endtask : rd
    task automatic t_regs;
        rd(OFF_VREG_IEN, d);
        chk("ien", 32'h0, d);
        rd(OFF_CHAN_MSK, d);
        chk("cmsk", 32'h0, d);
        wr(OFF_CHAN_MSK, 32'hFFFF_FFFF);
        rd(OFF_CHAN_MSK, d);
        chk("cmsk", 32'h0000_3FFF, d);
        rd(20'h00100, d);
        chk("unmapped", 32'h0, d);
    endtask : t_regs
    task automatic t_vreg;
        wr(OFF_VREG_IEN, 32'h2);
        wr(OFF_VREG_SET, 32'h1);
        chk("virq", 32'h0, {31'h0, virq});
        wr(OFF_VREG_SET, 32'h2);
        chk("virq", 32'h1, {31'h0, virq});
        wr(OFF_VREG_CLR, 32'h1);
        rd(OFF_VREG_FLAG, d);
        chk("flag", 32'h2, d);
        wr(OFF_VREG_CLR, 32'h2);
        rd(OFF_VREG_FLAG, d);
        chk("flag", 32'h0, d);
    endtask : t_vreg
    task automatic t_nak;
        rd(OFF_EP_SPACE, d);
        chk("space", 32'(TXF_DEPTH), d);
        wr(OFF_EP_CTRL, 32'h1); // Endpoint enabled before any push
        wr(OFF_FIFO6, 32'h0000_A001);
        wr(OFF_FIFO6, 32'h0000_A002);
        rd(OFF_EP_SPACE, d);
        chk("space", 32'(TXF_DEPTH - 2), d);
        i_peer.send(1'b0, r);
        chk("data", 32'h0000_A001, r.data);
        wr(OFF_DEV_CTRL, 32'h1);
        i_peer.send(1'b0, r);
        chk("kind", 32'(ANS_NAK), 32'(r.kind));
        chk("cirq", 32'h1, {31'h0, cirq});
        wr(OFF_CORE_MSK, 32'h0);
        chk("cirq", 32'h0, {31'h0, cirq});
        wr(OFF_DEV_CTRL, 32'h0);
        rd(OFF_CORE_STS, d);
        chk("eff", 32'h0, {31'h0, d[BIT_NAK_EFF]});
        wr(OFF_CORE_MSK, 32'h1); // Mask restored after leaving the mode
        // Next packet only after the previous one went out
        i_peer.send(1'b0, r);
        chk("data", 32'h0000_A002, r.data);
        chk("kind", 32'(ANS_DATA), 32'(r.kind));
        wr(OFF_EP_CTRL, 32'h1); // Zero-length queue, full space
    endtask : t_nak
    task automatic t_port;
        wr(OFF_CORE_MSK, 32'h2);
        @(posedge i_ref_clk);
        conn <= 1'b1;
        @(posedge i_ref_clk);
        conn <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        rd(OFF_PORT, d);
        chk("conn", 32'h1, {31'h0, d[BIT_CONN_DET]});
        chk("pirq", 32'h1, {31'h0, cirq});
        wr(OFF_PORT, 32'h0);
        chk("pirq", 32'h1, {31'h0, cirq});
        wr(OFF_PORT, 32'h0000_0002);
        chk("pirq", 32'h0, {31'h0, cirq});
        wr(OFF_EP_CTRL, 32'h30);
        wr(OFF_FIFO6, 32'h0000_B001);
        rd(OFF_EP_SPACE, d);
        chk("inpush", 32'(TXF_DEPTH), d);
        @(posedge i_ref_clk);
        rx <= 32'h0000_5A5A;
        rd(OFF_FIFO6, d);
        chk("fifo6", 32'h0000_5A5A, d);
        rd(OFF_FIFO7, d);
        chk("fifo7", 32'h0000_5A5A, d);
        @(posedge i_ref_clk);
        host <= 1'b0;
        rd(OFF_FIFO7, d);
        chk("fifo7dev", 32'h0, d);
        rd(OFF_FIFO6, d);
        chk("fifo6dev", 32'h0000_5A5A, d);
    endtask : t_port
    task automatic t_host;
        rd(OFF_PORT, d);
        chk("port", 32'h0, d);
        @(posedge i_ref_clk);
        host <= 1'b1;
        spd <= 2'h2;
        flags <= 14'h0005;
        rd(OFF_PORT, d);
        chk("spd", 32'h2, {30'h0, d[18:17]});
        rd(OFF_CHAN_SUM, d);
        chk("sum", 32'h5, d);
        wr(OFF_CORE_MSK, 32'h4);
        chk("cirq", 32'h1, {31'h0, cirq});
        wr(OFF_CHAN_MSK, 32'h2);
        chk("cirq", 32'h0, {31'h0, cirq});
    endtask : t_host
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        t_regs();
        t_vreg();
        t_nak();
        t_host();
        t_port();
        stop_test();
    end
    // Whole run needs about a hundred cycles; a hang ends here
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            stop_test();
        end
    end
endmodule : tb

// ==== bench/uoinh_monitor.sv ====
/*
 Port checker for uoinh_core.
 Sees only top ports; bound to the core after the module.
*/
`timescale 1ns/1ps
module uoinh_monitor (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire uoinh_pkg::uoinh_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic i_host_mode,
    input wire logic [uoinh_pkg::NCHAN-1:0] i_chan_flags,
    input wire logic [1:0] i_speed,
    input wire logic i_conn_det,
    input wire logic i_en_chng,
    input wire logic i_ovc_chng,
    input wire uoinh_pkg::uoinh_tok_t i_tok,
    input wire uoinh_pkg::uoinh_reply_t o_reply,
    input wire logic [31:0] i_rx_word,
    input wire logic o_vreg_irq,
    input wire logic o_core_irq
);
    import uoinh_pkg::*;
    // Shadows rebuilt from bus writes, so no peeking at internals
    logic nak_q;
    logic eff_q;
    logic msk_q;
    logic [1:0] ien_q;
    logic eff;
    assign eff = nak_q & eff_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            nak_q <= 1'b0;
            eff_q <= 1'b0;
            msk_q <= 1'b1;
            ien_q <= 2'h0;
        end else begin
            eff_q <= nak_q;
            if (i_bus.wr && i_bus.addr == OFF_DEV_CTRL) nak_q <= i_bus.wdata[0];
            if (i_bus.wr && i_bus.addr == OFF_CORE_MSK) msk_q <= i_bus.wdata[0];
            if (i_bus.wr && i_bus.addr == OFF_VREG_IEN) ien_q <= i_bus.wdata[1:0];
        end
    end
    sequence s_rd(logic [ADDR_W-1:0] a);
        i_bus.rd && i_bus.addr == a;
    endsequence
    sequence s_ntok;
        i_tok.token && !i_tok.iso && eff;
    endsequence
    property p_tok_stop;
        s_ntok |=> o_reply.kind != ANS_DATA;
    endproperty
    a_tok_stop: assert property (p_tok_stop) else $error("data sent in nak mode");
    property p_tok_nak;
        s_ntok |=> o_reply.kind == ANS_NAK;
    endproperty
    a_tok_nak: assert property (p_tok_nak) else $error("token not answered nak");
    property p_eff_irq;
        eff && msk_q |-> o_core_irq;
    endproperty
    a_eff_irq: assert property (p_eff_irq) else $error("effective irq missing");
    property p_eff_exit;
        s_rd(OFF_CORE_STS) ##0 !nak_q |=> !o_rdata[BIT_NAK_EFF];
    endproperty
    a_eff_exit: assert property (p_eff_exit) else $error("effective flag stuck");
    property p_set;
        i_bus.wr && i_bus.addr == OFF_VREG_SET && |(i_bus.wdata[1:0] & ien_q) |=> o_vreg_irq;
    endproperty
    a_set: assert property (p_set) else $error("set write lost");
    property p_clr;
        i_bus.wr && i_bus.addr == OFF_VREG_CLR && i_bus.wdata[1:0] == 2'h3 |=> !o_vreg_irq;
    endproperty
    a_clr: assert property (p_clr) else $error("clear write lost");
    property p_ien;
        ien_q == 2'h0 |-> !o_vreg_irq;
    endproperty
    a_ien: assert property (p_ien) else $error("sense irq not gated");
    property p_sum;
        s_rd(OFF_CHAN_SUM) ##0 $stable(i_chan_flags) |=> o_rdata == {18'h0, $past(i_chan_flags)};
    endproperty
    a_sum: assert property (p_sum) else $error("summary mismatch");
    property p_port_off;
        s_rd(OFF_PORT) ##0 !i_host_mode |=> o_rdata == WORD_ZERO;
    endproperty
    a_port_off: assert property (p_port_off) else $error("port seen in device mode");
    property p_spd;
        s_rd(OFF_PORT) ##0 i_host_mode && $stable(i_speed) |=> o_rdata[18:17] == $past(i_speed);
    endproperty
    a_spd: assert property (p_spd) else $error("speed field wrong");
endmodule : uoinh_monitor
bind uoinh_core uoinh_monitor i_mon (.*);

// ==== bench/uoinh_peer.sv ====
/*
 USB peer model: issues IN tokens and takes the reply.
 Assumes the core clock paces the token stream.
*/
`timescale 1ns/1ps
module uoinh_peer (
    input wire logic i_ref_clk,
    input wire uoinh_pkg::uoinh_reply_t i_reply,
    output uoinh_pkg::uoinh_tok_t o_tok
);
    import uoinh_pkg::*;
    initial o_tok = '0;
    // One-cycle token, reply taken only in the cycle it stands
    task automatic send(input logic iso, output uoinh_reply_t r);
        @(posedge i_ref_clk);
        o_tok <= '{token: 1'b1, iso: iso};
        @(posedge i_ref_clk);
        o_tok <= '0;
        #1;
        r = i_reply;
    endtask : send
endmodule : uoinh_peer

// ==== logic/uoinh_core.sv ====
/*
 Device-side slice of a USB OTG core: global non-periodic IN NAK, a small
 non-periodic transmit FIFO, regulator sense flags, host channel interrupt
 summary and mask, host port status with write-one-clear bits, FIFO windows.
 Assumes a plain register port (read data one cycle after the read strobe),
 and a packet engine that presents IN tokens on the core clock.
*/
// Operation
// - NAK set halts non-periodic IN transmission
// - NAK mode answers non-isochronous IN tokens NAK
// - Effective flag rises once transmission stopped
// - Data may still flow before effective flag
// - Clearing set bit exits mode, clears flag
// - FIFO holds several packets while space remains
// - Set register bits set sense flags
// - Clear register bits clear sense flags
// - Enable register gates sense interrupts, resets zero
// - Summary bit per channel mirrors channel flags
// - Channel mask gates summary irq, resets zero
// - Port status bits raise port irq, W1C
// - Port reports speed, exists in host mode only
// - FIFO windows pop IN channels, window six pushes OUT
// - Window six shared, window seven host only
`timescale 1ns/1ps
module uoinh_core (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire uoinh_pkg::uoinh_bus_t i_bus,
    output logic [31:0] o_rdata,
    input wire logic i_host_mode,
    input wire logic [uoinh_pkg::NCHAN-1:0] i_chan_flags,
    input wire logic [1:0] i_speed,
    input wire logic i_conn_det,
    input wire logic i_en_chng,
    input wire logic i_ovc_chng,
    input wire uoinh_pkg::uoinh_tok_t i_tok,
    output uoinh_pkg::uoinh_reply_t o_reply,
    input wire logic [31:0] i_rx_word,
    output logic o_vreg_irq,
    output logic o_core_irq
);
    import uoinh_pkg::*;

    typedef struct packed {
        logic [1:0] sense_flag;
        logic [1:0] sense_ien;
        logic nak_set;
        logic nak_eff;
        logic nak_eff_msk;
        logic port_irq_msk;
        logic chan_irq_msk_core;
        logic ep_ena;
        logic [1:0] ch_in;
        logic [NCHAN-1:0] chan_msk;
        logic [2:0] port_w1c;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [TXF_DEPTH-1:0][31:0] mem;
        logic [TXF_AW-1:0] wp;
        logic [TXF_AW-1:0] rp;
        logic [TXF_AW:0] cnt;
        uoinh_reply_t reply;
        logic [31:0] rdata;
    } uoinh_state_t;

    uoinh_state_t st;
    uoinh_state_t next_st;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic [NCHAN-1:0] chan_sum;
    logic chan_any;
    logic port_any;
    logic tx_push;
    logic tx_pop;
    logic [31:0] port_word;

    always_comb begin
        chan_sum = i_chan_flags;
        chan_any = |(chan_sum & st.chan_msk);
        port_any = |st.port_w1c;
        port_word = WORD_ZERO;
        port_word[SPD_LO +: 2] = i_speed;
        port_word[BIT_CONN_DET] = st.port_w1c[0];
        port_word[BIT_EN_CHNG] = st.port_w1c[1];
        port_word[BIT_OVC_CHNG] = st.port_w1c[2];
        // Pushes beyond space are dropped; software checks space first
        tx_push = i_bus.wr && hit(i_bus.addr, OFF_FIFO6) && !st.ch_in[BIT_CH6_IN]
            && st.cnt != TXF_FULL;
        // Eligible to send only with endpoint enabled and no NAK in force
        tx_pop = i_tok.token && !i_tok.iso && !st.nak_set && st.ep_ena
            && st.cnt != '0;
    end

    always_comb begin
        next_st = st;
        next_st.reply.kind = ANS_NONE;
        next_st.rdata = WORD_ZERO;
        // Pin-side status passes two flops before use
        next_st.pin_s1 = {i_ovc_chng, i_en_chng, i_conn_det};
        next_st.pin_s2 = st.pin_s1;
        // Effective flag rises once no token can be served, follows set bit
        next_st.nak_eff = st.nak_set;
        if (i_tok.token) begin
            if (tx_pop) begin
                next_st.reply.kind = ANS_DATA;
                next_st.reply.data = st.mem[st.rp];
                next_st.rp = st.rp + 1'b1;
            end else if (!i_tok.iso) begin
                next_st.reply.kind = ANS_NAK;
            end
        end
        if (tx_push) begin
            next_st.mem[st.wp] = i_bus.wdata;
            next_st.wp = st.wp + 1'b1;
        end
        next_st.cnt = st.cnt + {{TXF_AW{1'b0}}, tx_push} - {{TXF_AW{1'b0}}, tx_pop};
        if (i_bus.wr) begin
            if (hit(i_bus.addr, OFF_VREG_CLR))
                next_st.sense_flag = st.sense_flag & ~i_bus.wdata[1:0];
            if (hit(i_bus.addr, OFF_VREG_SET))
                next_st.sense_flag = st.sense_flag | i_bus.wdata[1:0];
            if (hit(i_bus.addr, OFF_VREG_IEN))
                next_st.sense_ien = i_bus.wdata[1:0];
            if (hit(i_bus.addr, OFF_DEV_CTRL)) begin
                next_st.nak_set = i_bus.wdata[BIT_NAK_SET];
                if (!i_bus.wdata[BIT_NAK_SET])
                    next_st.nak_eff = 1'b0;
            end
            if (hit(i_bus.addr, OFF_CORE_MSK)) begin
                next_st.nak_eff_msk = i_bus.wdata[BIT_NAK_EFF];
                next_st.port_irq_msk = i_bus.wdata[BIT_PORT_IRQ];
                next_st.chan_irq_msk_core = i_bus.wdata[BIT_CHAN_IRQ];
            end
            if (hit(i_bus.addr, OFF_EP_CTRL)) begin
                next_st.ep_ena = i_bus.wdata[BIT_EP_ENA];
                next_st.ch_in[BIT_CH6_IN] = i_bus.wdata[4 + BIT_CH6_IN];
                next_st.ch_in[BIT_CH7_IN] = i_bus.wdata[4 + BIT_CH7_IN];
            end
            if (hit(i_bus.addr, OFF_CHAN_MSK))
                next_st.chan_msk = i_bus.wdata[NCHAN-1:0];
            if (hit(i_bus.addr, OFF_PORT) && i_host_mode)
                next_st.port_w1c = st.port_w1c & ~{i_bus.wdata[BIT_OVC_CHNG],
                    i_bus.wdata[BIT_EN_CHNG], i_bus.wdata[BIT_CONN_DET]};
        end
        // Hardware set wins over a same-cycle software clear
        next_st.port_w1c = next_st.port_w1c | st.pin_s2;
        if (i_bus.rd) begin
            if (hit(i_bus.addr, OFF_VREG_FLAG))
                next_st.rdata[1:0] = st.sense_flag;
            if (hit(i_bus.addr, OFF_VREG_IEN))
                next_st.rdata[1:0] = st.sense_ien;
            if (hit(i_bus.addr, OFF_DEV_CTRL))
                next_st.rdata[BIT_NAK_SET] = st.nak_set;
            if (hit(i_bus.addr, OFF_CORE_STS)) begin
                next_st.rdata[BIT_NAK_EFF] = st.nak_eff;
                next_st.rdata[BIT_PORT_IRQ] = port_any && i_host_mode;
                next_st.rdata[BIT_CHAN_IRQ] = chan_any && i_host_mode;
            end
            if (hit(i_bus.addr, OFF_CORE_MSK))
                next_st.rdata[2:0] = {st.chan_irq_msk_core, st.port_irq_msk, st.nak_eff_msk};
            if (hit(i_bus.addr, OFF_EP_CTRL))
                next_st.rdata[5:0] = {st.ch_in, 3'h0, st.ep_ena};
            if (hit(i_bus.addr, OFF_EP_SPACE))
                next_st.rdata[TXF_AW:0] = TXF_FULL - st.cnt;
            if (hit(i_bus.addr, OFF_CHAN_SUM))
                next_st.rdata[NCHAN-1:0] = chan_sum;
            if (hit(i_bus.addr, OFF_CHAN_MSK))
                next_st.rdata[NCHAN-1:0] = st.chan_msk;
            if (hit(i_bus.addr, OFF_PORT) && i_host_mode)
                next_st.rdata = port_word;
            // IN channel windows pop received data; window seven host only
            if (hit(i_bus.addr, OFF_FIFO6) && st.ch_in[BIT_CH6_IN])
                next_st.rdata = i_rx_word;
            if (hit(i_bus.addr, OFF_FIFO7) && st.ch_in[BIT_CH7_IN] && i_host_mode)
                next_st.rdata = i_rx_word;
        end
        if (!i_nrst) begin
            next_st = '0;
            next_st.sense_ien = W1C_ZERO;
            next_st.chan_msk = CHAN_MSK_RST;
            next_st.nak_eff_msk = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        st <= next_st;
    end

    assign o_rdata = st.rdata;
    assign o_reply = st.reply;
    assign o_vreg_irq = |(st.sense_flag & st.sense_ien);
    assign o_core_irq = (st.nak_eff && st.nak_eff_msk)
        || (i_host_mode && port_any && st.port_irq_msk)
        || (i_host_mode && chan_any && st.chan_irq_msk_core);
endmodule : uoinh_core

// ==== logic/uoinh_pkg.sv ====
/*
 Package for the USB IN NAK and host interrupt block: register offsets,
 field positions, reset values and carrier structs.
 Assumes a word-addressed-by-byte plain register port with 20-bit address.
*/
package uoinh_pkg;
    localparam int ADDR_W = 20;
    localparam int NCHAN = 14;
    // Byte addresses of registers
    localparam logic [ADDR_W-1:0] OFF_VREG_FLAG = 20'h0000C;
    localparam logic [ADDR_W-1:0] OFF_VREG_SET = 20'h00008;
    localparam logic [ADDR_W-1:0] OFF_VREG_CLR = 20'h00010;
    localparam logic [ADDR_W-1:0] OFF_VREG_IEN = 20'h00014;
    localparam logic [ADDR_W-1:0] OFF_DEV_CTRL = 20'h00020;
    localparam logic [ADDR_W-1:0] OFF_CORE_STS = 20'h00024;
    localparam logic [ADDR_W-1:0] OFF_CORE_MSK = 20'h00028;
    localparam logic [ADDR_W-1:0] OFF_EP_CTRL = 20'h0002C;
    localparam logic [ADDR_W-1:0] OFF_EP_SPACE = 20'h00030;
    localparam logic [ADDR_W-1:0] OFF_CHAN_SUM = 20'h3C414;
    localparam logic [ADDR_W-1:0] OFF_CHAN_MSK = 20'h3C418;
    localparam logic [ADDR_W-1:0] OFF_PORT = 20'h3C440;
    localparam logic [ADDR_W-1:0] OFF_FIFO6 = 20'h43000;
    localparam logic [ADDR_W-1:0] OFF_FIFO7 = 20'h44000;
    // Field positions
    localparam int BIT_SENSE_LOW = 1;
    localparam int BIT_SENSE_HIGH = 0;
    localparam int BIT_NAK_SET = 0;
    localparam int BIT_NAK_EFF = 0;
    localparam int BIT_PORT_IRQ = 1;
    localparam int BIT_CHAN_IRQ = 2;
    localparam int BIT_EP_ENA = 0;
    localparam int BIT_CH7_IN = 1;
    localparam int BIT_CH6_IN = 0;
    localparam int BIT_CONN_DET = 1;
    localparam int BIT_EN_CHNG = 3;
    localparam int BIT_OVC_CHNG = 5;
    localparam int SPD_LO = 17;
    localparam logic [1:0] W1C_ZERO = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [NCHAN-1:0] CHAN_MSK_RST = 14'h0000;
    localparam logic [31:0] PORT_W1C_BITS = 32'h0000_002A;
    // Transmit FIFO depth in words, its pointer width and full count
    localparam int TXF_DEPTH = 16;
    localparam int TXF_AW = 4;
    localparam logic [TXF_AW:0] TXF_FULL = 5'h10;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } uoinh_bus_t;

    typedef struct packed {
        logic token;
        logic iso;
    } uoinh_tok_t;

    typedef enum logic [1:0] {
        ANS_NONE,
        ANS_DATA,
        ANS_NAK
    } uoinh_ans_t;

    typedef struct packed {
        uoinh_ans_t kind;
        logic [31:0] data;
    } uoinh_reply_t;
endpackage : uoinh_pkg
